// File: design/oscg_top.sv
// oscillator settling wait, settle status and clock source control
// What the block and its software must do
// R1 - reset loads settle select with 05H
// R2 - codes 1..5 pick 2^11..2^16 crystal periods
// R3 - wait applies only on crystal-clocked STOP release
// R4 - software polls status on other clocks
// R5 - software writes select as whole byte
// R6 - software sets select before STOP
// R7 - software leaves select alone during wait
// R8 - counter stops at selected wait
// R9 - software picks select no shorter than polled
// R10 - wait counts only real crystal periods
// R11 - fast internal oscillator starts after reset
// R12 - CPU starts on fast internal clock
// R13 - mode register starts and stops fast oscillator
// R14 - slow clock never becomes CPU clock
// R15 - option decides if slow oscillator stoppable
// R16 - slow oscillator and watchdog run after reset
// R17 - prescaler divides main clock when selected
// R18 - subsystem pins are I/O when unselected
// R19 - status bits set ascending and stay
// R20 - status clears on reset, STOP, crystal stop
// R21 - CPU clock held until wait done
// R22 - restartable counter drives wait and status
`timescale 1ns/1ns
module oscg_top
   import oscg_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic [15:0] i_bus_addr,
   input wire logic [7:0] i_bus_wdata,
   input wire logic i_bus_wr,
   input wire logic i_bus_rd,
   output logic [7:0] o_bus_rdata,
   input wire logic i_xtal_clk,
   input wire logic i_stop_exec,
   input wire logic i_stop_release,
   input wire logic [1:0] i_cpu_clk_sel,
   input wire logic i_slow_osc_stoppable,
   output logic o_cpu_clk_hold,
   output logic [1:0] o_cpu_src,
   output logic o_fast_osc_en,
   output logic o_slow_osc_en,
   output logic o_xtal_osc_en,
   output logic o_sub_pins_io,
   output logic [PRESC_W-1:0] o_presc_div
);
   logic [7:0] osc_settle_select_reg, osc_settle_select_next;
   logic [7:0] clock_mode_reg, clock_mode_next;
   logic [7:0] main_osc_control_reg, main_osc_control_next;
   logic [7:0] internal_osc_mode_reg, internal_osc_mode_next;
   logic [7:0] rdata_reg, rdata_next;
   oscg_state_e state_reg, state_next;
   logic [1:0] cpu_src_reg, cpu_src_next;
   logic [PRESC_W-1:0] presc_reg, presc_next;
   logic xtal_s1_reg, xtal_s2_reg, xtal_s3_reg;
   logic xtal_edge, cnt_clear, cnt_restart, settle_done;
   logic [STATUS_W-1:0] osc_settle_status;
   logic wr_select, wr_moc_stop;

   // crystal pin is foreign to i_ref_clk: two flops, then edge detect on the second
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         xtal_s1_reg <= 1'b0;
         xtal_s2_reg <= 1'b0;
         xtal_s3_reg <= 1'b0;
      end else begin
         xtal_s1_reg <= i_xtal_clk;
         xtal_s2_reg <= xtal_s1_reg;
         xtal_s3_reg <= xtal_s2_reg;
      end
   end
   // crystal must stay well below half of i_ref_clk for edges to be seen
   assign xtal_edge = xtal_s2_reg && !xtal_s3_reg && o_xtal_osc_en; // R10

   assign wr_select = i_bus_wr && (i_bus_addr == ADDR_SETTLE_SELECT);
   assign wr_moc_stop = i_bus_wr && (i_bus_addr == ADDR_MAIN_OSC_CTRL) && i_bus_wdata[CRYSTAL_OSC_STOP_BIT];
   assign cnt_clear = i_stop_exec || wr_moc_stop || main_osc_control_reg[CRYSTAL_OSC_STOP_BIT]; // R20
   assign cnt_restart = (state_reg == ST_STOPPED) && i_stop_release; // R22

   oscg_settle_counter #(
      .CNT_W(SETTLE_CNT_W)
   ) u_counter (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_clear(cnt_clear),
      .i_restart(cnt_restart),
      .i_xtal_edge(xtal_edge),
      .i_code(osc_settle_select_reg[SETTLE_CODE_W-1:0]),
      .o_status(osc_settle_status),
      .o_done(settle_done)
   );

   // register file
   always_comb begin
      osc_settle_select_next = osc_settle_select_reg;
      clock_mode_next = clock_mode_reg;
      main_osc_control_next = main_osc_control_reg;
      internal_osc_mode_next = internal_osc_mode_reg;
      rdata_next = rdata_reg;
      if (wr_select) begin
         osc_settle_select_next = {5'h00, i_bus_wdata[SETTLE_CODE_W-1:0]}; // R5
      end else if (i_bus_wr && (i_bus_addr == ADDR_CLOCK_MODE)) begin
         clock_mode_next = i_bus_wdata & CLOCK_MODE_MASK;
      end else if (i_bus_wr && (i_bus_addr == ADDR_MAIN_OSC_CTRL)) begin
         main_osc_control_next = i_bus_wdata & MAIN_OSC_CTRL_RST;
      end else if (i_bus_wr && (i_bus_addr == ADDR_INT_OSC_MODE)) begin
         internal_osc_mode_next = {6'h00, i_bus_wdata[SLOW_OSC_STOP_BIT:FAST_OSC_STOP_BIT]}; // R13
      end
      if (!i_bus_rd) begin
         rdata_next = 8'h00;
      end else if (i_bus_addr == ADDR_SETTLE_SELECT) begin
         rdata_next = osc_settle_select_reg;
      end else if (i_bus_addr == ADDR_SETTLE_STATUS) begin
         rdata_next = {3'h0, osc_settle_status}; // R4
      end else if (i_bus_addr == ADDR_CLOCK_MODE) begin
         rdata_next = clock_mode_reg;
      end else if (i_bus_addr == ADDR_MAIN_OSC_CTRL) begin
         rdata_next = main_osc_control_reg;
      end else if (i_bus_addr == ADDR_INT_OSC_MODE) begin
         rdata_next = internal_osc_mode_reg;
      end else begin
         rdata_next = 8'h00;
      end
   end

   // STOP sequencing, CPU source and prescaler
   always_comb begin
      state_next = state_reg;
      cpu_src_next = cpu_src_reg;
      presc_next = presc_reg;
      case (state_reg)
         ST_RUN: begin
            if (i_stop_exec) begin
               state_next = ST_STOPPED;
            end else if (i_cpu_clk_sel == CPU_CRYSTAL || i_cpu_clk_sel == CPU_SUBSYS) begin
               cpu_src_next = i_cpu_clk_sel;
            end else begin
               cpu_src_next = CPU_INT_FAST; // R14
            end
         end
         ST_STOPPED: begin
            if (i_stop_release) begin
               state_next = (cpu_src_reg == CPU_CRYSTAL) ? ST_SETTLE : ST_RUN; // R3
            end
         end
         ST_SETTLE: begin
            if (settle_done) begin
               state_next = ST_RUN; // R21
            end
         end
         default: state_next = ST_RUN;
      endcase
      if (state_reg != ST_RUN || cpu_src_reg == CPU_SUBSYS) begin
         presc_next = '0;
      end else begin
         presc_next = presc_reg + PRESC_W'(1); // R17
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         osc_settle_select_reg <= SETTLE_SELECT_RST; // R1
         clock_mode_reg <= CLOCK_MODE_RST;
         main_osc_control_reg <= MAIN_OSC_CTRL_RST;
         internal_osc_mode_reg <= INT_OSC_MODE_RST; // R11 R16
         rdata_reg <= 8'h00;
         state_reg <= ST_RUN;
         cpu_src_reg <= CPU_INT_FAST; // R12
         presc_reg <= '0;
      end else begin
         osc_settle_select_reg <= osc_settle_select_next;
         clock_mode_reg <= clock_mode_next;
         main_osc_control_reg <= main_osc_control_next;
         internal_osc_mode_reg <= internal_osc_mode_next;
         rdata_reg <= rdata_next;
         state_reg <= state_next;
         cpu_src_reg <= cpu_src_next;
         presc_reg <= presc_next;
      end
   end

   assign o_bus_rdata = rdata_reg;
   assign o_cpu_src = cpu_src_reg;
   assign o_presc_div = presc_reg;
   assign o_cpu_clk_hold = (state_reg != ST_RUN); // R21
   assign o_fast_osc_en = !internal_osc_mode_reg[FAST_OSC_STOP_BIT] && (state_reg != ST_STOPPED); // R11 R13
   assign o_slow_osc_en = !(i_slow_osc_stoppable && internal_osc_mode_reg[SLOW_OSC_STOP_BIT]); // R15 R16
   assign o_xtal_osc_en = !main_osc_control_reg[CRYSTAL_OSC_STOP_BIT] && (state_reg != ST_STOPPED);
   assign o_sub_pins_io = !clock_mode_reg[SUB_OSC_SELECT_BIT]; // R18

   sequence s_xtal_release;
      (state_reg == ST_STOPPED) && i_stop_release && (cpu_src_reg == CPU_CRYSTAL);
   endsequence
   sequence s_other_release;
      (state_reg == ST_STOPPED) && i_stop_release && (cpu_src_reg != CPU_CRYSTAL);
   endsequence

   a_select_byte_write: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R5
      $changed(osc_settle_select_reg) |-> $past(wr_select) && osc_settle_select_reg[7:3] == 5'h00)
      else $error("settle select changed without a write");
   a_settle_applies: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R3
      s_xtal_release |=> (state_reg == ST_SETTLE) && o_cpu_clk_hold)
      else $error("crystal release skipped the settling wait");
   a_no_wait_other: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R3
      s_other_release |=> !o_cpu_clk_hold)
      else $error("non-crystal release was held");
   a_hold_until_done: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R21
      (state_reg == ST_SETTLE && !settle_done) |=> o_cpu_clk_hold)
      else $error("cpu clock released before settling done");
   a_status_ascend: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R19
      osc_settle_status inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F})
      else $error("status bits not set in ascending order");
   a_status_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R19
      (osc_settle_status != 5'h00 && !cnt_clear && !cnt_restart) |=>
      ($past(osc_settle_status) & ~osc_settle_status) == 5'h00)
      else $error("status bit dropped without a clear");
   a_status_clear: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R20
      (i_stop_exec || wr_moc_stop) |=> osc_settle_status == 5'h00)
      else $error("status not cleared");
   a_slow_unstoppable: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R15
      !i_slow_osc_stoppable |-> o_slow_osc_en)
      else $error("unstoppable slow oscillator was stopped");
   a_cpu_not_slow: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R14
      (state_reg == ST_RUN && i_cpu_clk_sel == 2'h3 && !i_stop_exec) |=> o_cpu_src == CPU_INT_FAST)
      else $error("slow clock reached the cpu");
endmodule // oscg_top

// File: design/oscg_pkg.sv
// constants and types for the oscillator settling and clock generator block
package oscg_pkg;
   localparam logic [15:0] ADDR_SETTLE_SELECT = 16'hFFA4;
   localparam logic [15:0] ADDR_SETTLE_STATUS = 16'hFFA3;
   localparam logic [15:0] ADDR_CLOCK_MODE = 16'hFFEF;
   localparam logic [15:0] ADDR_MAIN_OSC_CTRL = 16'hFFA2;
   localparam logic [15:0] ADDR_INT_OSC_MODE = 16'hFFA0;
   localparam logic [7:0] SETTLE_SELECT_RST = 8'h05;
   localparam logic [7:0] SETTLE_STATUS_RST = 8'h00;
   localparam logic [7:0] CLOCK_MODE_RST = 8'h00;
   localparam logic [7:0] CLOCK_MODE_MASK = 8'hF1;
   localparam logic [7:0] MAIN_OSC_CTRL_RST = 8'h80;
   localparam logic [7:0] INT_OSC_MODE_RST = 8'h00;
   localparam int SETTLE_CODE_W = 3;
   localparam int SUB_OSC_SELECT_BIT = 4;
   localparam int CRYSTAL_OSC_STOP_BIT = 7;
   localparam int FAST_OSC_STOP_BIT = 0;
   localparam int SLOW_OSC_STOP_BIT = 1;
   localparam logic [2:0] CODE_2P11 = 3'h1;
   localparam logic [2:0] CODE_2P13 = 3'h2;
   localparam logic [2:0] CODE_2P14 = 3'h3;
   localparam logic [2:0] CODE_2P15 = 3'h4;
   localparam logic [2:0] CODE_2P16 = 3'h5;
   localparam int EXP_2P11 = 11;
   localparam int EXP_2P13 = 13;
   localparam int EXP_2P14 = 14;
   localparam int EXP_2P15 = 15;
   localparam int EXP_2P16 = 16;
   localparam int SETTLE_CNT_W = EXP_2P16 + 1;
   localparam int STATUS_W = 5;
   localparam int PRESC_W = 5;
   // status bit i (bit 4 is the shortest wait) reached at 2**SETTLE_EXP[i]
   localparam int SETTLE_EXP [STATUS_W] = '{EXP_2P16, EXP_2P15, EXP_2P14, EXP_2P13, EXP_2P11};
   localparam logic [1:0] CPU_INT_FAST = 2'h0;
   localparam logic [1:0] CPU_CRYSTAL = 2'h1;
   localparam logic [1:0] CPU_SUBSYS = 2'h2;
   typedef enum logic [1:0] {ST_RUN, ST_STOPPED, ST_SETTLE} oscg_state_e;
endpackage

// File: design/oscg_settle_counter.sv
// crystal settling counter with sticky threshold status
`timescale 1ns/1ns
module oscg_settle_counter
   import oscg_pkg::*;
#(
   parameter int CNT_W = SETTLE_CNT_W
) (
   input wire logic i_ref_clk,
   input wire logic i_nrst,
   input wire logic i_clear,
   input wire logic i_restart,
   input wire logic i_xtal_edge,
   input wire logic [SETTLE_CODE_W-1:0] i_code,
   output logic [STATUS_W-1:0] o_status,
   output logic o_done
);
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [STATUS_W-1:0] status_reg, status_next, reached;
   logic [CNT_W-1:0] limit;

   // prohibited codes fall back to the longest wait, the safe side
   function automatic int code_exp(input logic [SETTLE_CODE_W-1:0] code);
      case (code)
         CODE_2P11: code_exp = EXP_2P11;
         CODE_2P13: code_exp = EXP_2P13;
         CODE_2P14: code_exp = EXP_2P14;
         CODE_2P15: code_exp = EXP_2P15;
         default: code_exp = EXP_2P16;
      endcase
   endfunction

   assign limit = CNT_W'(1) << code_exp(i_code); // R2
   assign o_done = (cnt_reg >= limit); // R21

   genvar g;
   generate
      for (g = 0; g < STATUS_W; g++) begin : g_thr
         assign reached[g] = (cnt_reg >= (CNT_W'(1) << SETTLE_EXP[g])); // R22
      end
   endgenerate

   always_comb begin
      cnt_next = cnt_reg;
      if (i_clear || i_restart) begin
         cnt_next = '0; // R22
      end else if (i_xtal_edge && !o_done) begin
         cnt_next = cnt_reg + CNT_W'(1); // R8 R10
      end
      // clearing beats a threshold hit: the hit belongs to the count being discarded
      status_next = (i_clear || i_restart) ? '0 : (status_reg | reached); // R19 R20
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_reg <= '0;
         status_reg <= STATUS_W'(SETTLE_STATUS_RST); // R20
      end else begin
         cnt_reg <= cnt_next;
         status_reg <= status_next;
      end
   end

   assign o_status = status_reg;

   a_count_capped: assert property (@(posedge i_ref_clk) disable iff (!i_nrst) // R8
      (o_done && !i_restart && !i_clear) |=> $stable(cnt_reg))
      else $error("settle counter ran past selected wait");
endmodule // oscg_settle_counter

// File: tb/oscg_top_test.sv
// self-checking bench for the oscillator settling and clock generator block
`timescale 1ns/1ns
module oscg_top_test;
   import oscg_pkg::*;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [15:0] bus_addr = 16'h0000;
   logic [7:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic xtal_clk = 1'b0;
   logic stop_exec = 1'b0;
   logic stop_release = 1'b0;
   logic [1:0] cpu_clk_sel = 2'h0;
   logic slow_stoppable = 1'b0;
   logic [7:0] bus_rdata;
   logic cpu_clk_hold;
   logic [1:0] cpu_src;
   logic fast_en;
   logic slow_en;
   logic xtal_en;
   logic sub_io;
   logic [PRESC_W-1:0] presc_div;
   logic [PRESC_W-1:0] presc_prev;
   int mismatches = 0;
   int n_checks = 0;
   int cyc;

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   // crystal at 10 MHz, off phase with the reference; well under ref/2
   initial begin
      #3;
      forever #50 xtal_clk = ~xtal_clk;
   end

   oscg_top DUT (
      .i_ref_clk(ref_clk),
      .i_nrst(nrst),
      .i_bus_addr(bus_addr),
      .i_bus_wdata(bus_wdata),
      .i_bus_wr(bus_wr),
      .i_bus_rd(bus_rd),
      .o_bus_rdata(bus_rdata),
      .i_xtal_clk(xtal_clk),
      .i_stop_exec(stop_exec),
      .i_stop_release(stop_release),
      .i_cpu_clk_sel(cpu_clk_sel),
      .i_slow_osc_stoppable(slow_stoppable),
      .o_cpu_clk_hold(cpu_clk_hold),
      .o_cpu_src(cpu_src),
      .o_fast_osc_en(fast_en),
      .o_slow_osc_en(slow_en),
      .o_xtal_osc_en(xtal_en),
      .o_sub_pins_io(sub_io),
      .o_presc_div(presc_div)
   );

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
      #1;
   endtask

   // read data is registered at the taking edge, so it is sampled just after it
   task automatic rd_chk(input string name, input logic [15:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1;
      check(name, exp, bus_rdata);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // enter stop, check the stopped state, release, count cycles until hold drops
   task automatic stop_run(input logic [1:0] sel, output int c);
      @(posedge ref_clk);
      cpu_clk_sel <= sel;
      wait_cyc(2);
      @(posedge ref_clk);
      stop_exec <= 1'b1;
      @(posedge ref_clk);
      stop_exec <= 1'b0;
      wait_cyc(3);
      check("hold_in_stop", 8'h01, {7'h00, cpu_clk_hold});
      check("xtal_en_in_stop", 8'h00, {7'h00, xtal_en});
      rd_chk("status_after_stop", ADDR_SETTLE_STATUS, 8'h00);
      @(posedge ref_clk);
      stop_release <= 1'b1;
      @(posedge ref_clk);
      stop_release <= 1'b0;
      #1;
      c = 0;
      while (cpu_clk_hold === 1'b1 && c < 30000) begin
         wait_cyc(1);
         c++;
      end
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      wait_cyc(1);
      check("fast_en_rst", 8'h01, {7'h00, fast_en});
      check("slow_en_rst", 8'h01, {7'h00, slow_en});
      check("cpu_src_rst", 8'h00, {6'h00, cpu_src});
      check("sub_io_rst", 8'h01, {7'h00, sub_io});
      rd_chk("select_rst", ADDR_SETTLE_SELECT, 8'h05);
      rd_chk("status_rst", ADDR_SETTLE_STATUS, 8'h00);
      for (int k = 1; k <= 5; k++) begin
         reg_wr(ADDR_SETTLE_SELECT, 8'(k));
         rd_chk("select_code", ADDR_SETTLE_SELECT, 8'(k));
      end
      // upper bits set around a legal code; prohibited codes are never written
      reg_wr(ADDR_SETTLE_SELECT, 8'hFD);
      rd_chk("select_upper_bits", ADDR_SETTLE_SELECT, 8'h05);
      rd_chk("unmapped", 16'hFFA5, 8'h00);
      cpu_clk_sel <= 2'h3;
      wait_cyc(3);
      check("slow_not_cpu", 8'h00, {6'h00, cpu_src});
      presc_prev = presc_div;
      wait_cyc(1);
      check("presc_runs", 8'h01, {7'h00, presc_div !== presc_prev});
      cpu_clk_sel <= 2'h2;
      wait_cyc(3);
      check("presc_sub_zero", 8'h00, {3'h0, presc_div});
      reg_wr(ADDR_CLOCK_MODE, 8'h10);
      check("sub_io_off", 8'h00, {7'h00, sub_io});
      reg_wr(ADDR_CLOCK_MODE, 8'h00);
      // shortest wait keeps the run short: 2^11 crystal periods of 5 ref cycles
      // select is set before the crystal starts, so no wait is ever in progress then
      reg_wr(ADDR_SETTLE_SELECT, 8'h01);
      reg_wr(ADDR_MAIN_OSC_CTRL, 8'h00);
      check("xtal_en_on", 8'h01, {7'h00, xtal_en});
      cpu_clk_sel <= 2'h1;
      wait_cyc(3);
      check("cpu_src_xtal", 8'h01, {6'h00, cpu_src});
      reg_wr(ADDR_INT_OSC_MODE, 8'h01);
      check("fast_stop", 8'h00, {7'h00, fast_en});
      reg_wr(ADDR_INT_OSC_MODE, 8'h02);
      check("fast_restart", 8'h01, {7'h00, fast_en});
      check("slow_locked", 8'h01, {7'h00, slow_en});
      slow_stoppable <= 1'b1;
      wait_cyc(2);
      check("slow_stoppable", 8'h00, {7'h00, slow_en});
      reg_wr(ADDR_INT_OSC_MODE, 8'h00);
      stop_run(2'h1, cyc);
      check("xtal_wait_len", 8'h01, {7'h00, cyc >= 10230 && cyc <= 10260});
      rd_chk("status_xtal_done", ADDR_SETTLE_STATUS, 8'h10);
      cpu_clk_sel <= 2'h0;
      wait_cyc(3);
      reg_wr(ADDR_MAIN_OSC_CTRL, 8'h80);
      rd_chk("status_xtal_stop", ADDR_SETTLE_STATUS, 8'h00);
      reg_wr(ADDR_MAIN_OSC_CTRL, 8'h00);
      stop_run(2'h0, cyc);
      check("fast_no_wait", 8'h01, {7'h00, cyc <= 1});
      wait_cyc(5000);
      rd_chk("status_midway", ADDR_SETTLE_STATUS, 8'h00);
      wait_cyc(5500);
      rd_chk("status_reached", ADDR_SETTLE_STATUS, 8'h10);
      // run past 2^13 crystal periods so an uncapped counter would set the next bit
      wait_cyc(32000);
      rd_chk("status_capped", ADDR_SETTLE_STATUS, 8'h10);
      end_of_test();
   end

   // whole sequence needs about 55000 cycles
   initial begin
      repeat (80000) @(posedge ref_clk);
      mismatches++;
      $display("watchdog expired");
      end_of_test();
   end
endmodule // oscg_top_test
